// ### rtl/pmt_target.sv
// power-management serial target: byte engine, command decode, store and alert
// assumes open-drain wires resolved outside; SCL arrives as the link clock
`timescale 1ns/1ps
`default_nettype none
`include "pmt_target_params.svh"

module pmt_target
  import pmt_pkg::*;
#(
  parameter logic [7:0]  MAX_PHASE_DEF = 8'h06,
  parameter logic [7:0]  PHASE_EN_DEF  = 8'h3f,
  // arbitrary identification value
  parameter logic [15:0] DEVICE_ID     = 16'h5a3c
) (
  // system
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // bus pins
  input  wire logic        I_SCL,
  input  wire logic        I_SDA,
  output pmt_pins_s        O_PINS,
  // straps
  input  wire logic [6:0]  I_ADDR_STRAP,
  input  wire logic        I_STRAP_MODE,
  input  wire logic [7:0]  I_STRAP_MAX_OPERATING_CURRENT,
  input  wire logic [7:0]  I_STRAP_BOOT_VOLTAGE,
  // regulator side
  input  wire logic [10:0] I_PHASE_IMBAL,
  output pmt_cfg_t         O_CFG,
  output logic [15:0]      O_STATUS,
  output logic             O_NVM_STORE
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `PMT_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [3:0] idx_of(input logic [7:0] c);
    logic [3:0] r;
    r = `PMT_IDX_NONE;
    if (c >= `PMT_CMD_MAXCUR && c <= `PMT_CMD_UVLO) begin
      r = 4'(c - `PMT_CMD_MAXCUR);
    end else if (c >= `PMT_CMD_MAXPH && c <= `PMT_CMD_UVOFS) begin
      r = 4'(c - `PMT_CMD_MAXPH + 8'h07);
    end else if (c == `PMT_CMD_PHEN) begin
      r = 4'ha;
    end
    return r;
  endfunction

  // data bytes of a command; 3 marks an unsupported code
  function automatic logic [1:0] len_of(input logic [7:0] c);
    logic [1:0] r;
    r = 2'h3;
    if (idx_of(c) != `PMT_IDX_NONE) begin
      r = 2'h1;
    end else if (c == `PMT_CMD_IMBAL || c == `PMT_CMD_BOOTVID ||
                 c == `PMT_CMD_DEVID || c == `PMT_CMD_STATUS) begin
      r = 2'h2;
    end else if (c == `PMT_CMD_CLEAR || c == `PMT_CMD_STORE) begin
      r = 2'h0;
    end
    return r;
  endfunction

  // mantissa and exponent packed; the exponent is fixed per command
  function automatic logic [15:0] lin(input logic [10:0] m, input logic [4:0] e);
    return {e, m};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: one flop per bit, toggled so the system side sees each edge
  logic lk_bit_q;
  logic lk_tog_q;

  always_ff @(posedge I_SCL or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lk_bit_q <= 1'b1;
      lk_tog_q <= 1'b0;
    end else begin
      lk_bit_q <= I_SDA;
      lk_tog_q <= ~lk_tog_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers; plenty of margin at 40 MHz for a 400 kHz bus
  logic [2:0]  scl_s;
  logic [2:0]  sda_s;
  logic [2:0]  tog_s;
  logic [23:0] stp_s1;
  logic [23:0] stp_s2;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      scl_s  <= 3'h7;
      sda_s  <= 3'h7;
      tog_s  <= 3'h0;
      stp_s1 <= 24'h000000;
      stp_s2 <= 24'h000000;
    end else begin
      scl_s  <= {scl_s[1:0], I_SCL};
      sda_s  <= {sda_s[1:0], I_SDA};
      tog_s  <= {tog_s[1:0], lk_tog_q};
      stp_s1 <= {I_STRAP_MODE, I_ADDR_STRAP, I_STRAP_MAX_OPERATING_CURRENT, I_STRAP_BOOT_VOLTAGE};
      stp_s2 <= stp_s1;
    end
  end

  logic scl_fall;
  logic bit_ev;
  logic start_ev;
  logic stop_ev;
  logic rx_bit;
  assign scl_fall = scl_s[2] & ~scl_s[1];
  assign bit_ev   = tog_s[2] ^ tog_s[1];
  assign start_ev = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_ev  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
  assign rx_bit   = lk_bit_q;

  ////////////////////////////////////////////////////////////////////////////
  // boot: defaults from stored copy; in strap mode max current and boot voltage come from straps
  logic [1:0] boot_q;
  logic [6:0] own_q;
  logic       boot_ld;
  assign boot_ld = (boot_q == `PMT_BOOT_WAIT - 2'h1);

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      boot_q <= 2'h0;
      own_q  <= 7'h00;
    end else begin
      if (boot_q != `PMT_BOOT_WAIT) begin
        boot_q <= boot_q + 2'h1;
      end
      if (boot_ld) begin
        own_q <= stp_s2[22:16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  pmt_state_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [1:0] nb_q;
  logic [2:0] txi_q;
  logic [7:0] cmd_q;
  logic [7:0] d0_q;
  logic [7:0] crc_q;
  logic       pos_q;
  logic       rd_q;
  logic       ara_q;
  logic       ackd_q;
  logic       ack_en_q;
  logic       alert_q;
  pmt_cfg_t   cfg_q;
  pmt_cfg_t   nvm_q;
  logic       cml_q;
  logic       mfr_q;

  logic [7:0]  rxb;
  logic [15:0] rd_word;
  logic [1:0]  rlen;
  logic [7:0]  nxt_tx;
  assign rxb  = {sh_q[6:0], rx_bit};
  assign rlen = ara_q ? 2'h1 : len_of(cmd_q);

  always_comb begin
    rd_word = 16'hffff;
    if (idx_of(cmd_q) != `PMT_IDX_NONE) begin
      rd_word = {8'h00, cfg_q[idx_of(cmd_q)]};
    end else if (cmd_q == `PMT_CMD_IMBAL) begin
      rd_word = lin(`PMT_IMBAL_MANT, `PMT_IMBAL_EXP);
    end else if (cmd_q == `PMT_CMD_BOOTVID) begin
      rd_word = {8'h00, cfg_q[`PMT_IDX_BOOTV]};
    end else if (cmd_q == `PMT_CMD_DEVID) begin
      rd_word = DEVICE_ID;
    end else if (cmd_q == `PMT_CMD_STATUS) begin
      rd_word = O_STATUS;
    end
    if (ara_q) begin
      nxt_tx = (txi_q == 3'h0) ? {own_q, 1'b0} : 8'hff;
    end else if (txi_q == 3'h0) begin
      nxt_tx = rd_word[7:0];
    end else if (txi_q == 3'h1 && rlen == 2'h2) begin
      nxt_tx = rd_word[15:8];
    end else if (txi_q == {1'b0, rlen}) begin
      nxt_tx = crc_q;
    end else begin
      nxt_tx = 8'hff;
    end
  end

  // sequencing of the wire; SCL is only ever an input so no stretching exists
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q     <= ST_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      pos_q    <= 1'b0;
      ackd_q   <= 1'b0;
      ack_en_q <= 1'b0;
      txi_q    <= 3'h0;
      O_PINS   <= '0;
    end else if (start_ev) begin
      st_q          <= ST_RX;
      cnt_q         <= 4'h0;
      // every read starts at its first byte, whatever the last one left
      txi_q         <= 3'h0;
      pos_q         <= 1'b0;
      O_PINS.sda_oe <= 1'b0;
      O_PINS.alert_oe <= alert_q;
    end else if (stop_ev) begin
      st_q          <= ST_IDLE;
      O_PINS.sda_oe <= 1'b0;
      O_PINS.alert_oe <= alert_q;
    end else begin
      O_PINS.alert_oe <= alert_q;
      case (st_q)
        ST_RX: begin
          if (bit_ev) begin
            sh_q  <= rxb;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              st_q     <= ST_ACK;
              ackd_q   <= 1'b0;
              ack_en_q <= ~pos_q ? ((rxb[7:1] == own_q) ||
                          (rxb[7:1] == `PMT_ARA_ADDR && rxb[0] && alert_q)) : 1'b1;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall && !ackd_q) begin
            ackd_q        <= 1'b1;
            O_PINS.sda_oe <= ack_en_q;
          end else if (scl_fall) begin
            pos_q <= 1'b1;
            cnt_q <= 4'h0;
            if (!ack_en_q) begin
              st_q          <= ST_IDLE;
              O_PINS.sda_oe <= 1'b0;
            end else if (rd_q) begin
              st_q          <= ST_TX;
              txi_q         <= 3'h1;
              tx_q          <= {nxt_tx[6:0], 1'b0};
              O_PINS.sda_oe <= ~nxt_tx[7];
            end else begin
              st_q          <= ST_RX;
              O_PINS.sda_oe <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            O_PINS.sda_oe <= ~tx_q[7];
            tx_q          <= {tx_q[6:0], 1'b0};
          end
          if (bit_ev) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              st_q <= ST_RACK;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            O_PINS.sda_oe <= 1'b0;
          end
          if (bit_ev) begin
            cnt_q <= 4'h0;
            if (rx_bit) begin
              st_q <= ST_IDLE;
            end else begin
              st_q  <= ST_TX;
              txi_q <= txi_q + 3'h1;
              tx_q  <= nxt_tx;
            end
          end
        end
        default: begin
          O_PINS.sda_oe <= 1'b0;
        end
      endcase
      if (st_q == ST_ACK && scl_fall && ackd_q && rd_q) begin
        txi_q <= 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer bookkeeping and checksum over every byte on the wire except the checksum the target sends
  logic byte_done;
  logic tx_load;
  assign byte_done = (st_q == ST_RX) && bit_ev && (cnt_q == 4'h7);
  assign tx_load   = ((st_q == ST_ACK) && scl_fall && ackd_q && ack_en_q && rd_q) ||
                     ((st_q == ST_RACK) && bit_ev && !rx_bit);

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      crc_q <= 8'h00;
      cmd_q <= 8'h00;
      d0_q  <= 8'h00;
      nb_q  <= 2'h0;
      rd_q  <= 1'b0;
      ara_q <= 1'b0;
    end else begin
      if (start_ev && st_q == ST_IDLE) begin
        crc_q <= 8'h00;
        nb_q  <= 2'h0;
      end else if (byte_done) begin
        crc_q <= crc8(crc_q, rxb);
        if (!pos_q) begin
          rd_q  <= rxb[0];
          ara_q <= (rxb[7:1] == `PMT_ARA_ADDR);
        end
        if (pos_q && !rd_q) begin
          if (nb_q == 2'h0 && !ack_en_q) begin
            cmd_q <= rxb;
          end
        end
      end else if (tx_load && txi_q[1:0] != rlen) begin
        crc_q <= crc8(crc_q, nxt_tx);
      end
      // byte count after the address: command, data, checksum
      if (st_q == ST_ACK && scl_fall && !ackd_q && pos_q && !rd_q) begin
        if (nb_q == 2'h0) begin
          cmd_q <= sh_q;
        end else if (nb_q == 2'h1) begin
          d0_q <= sh_q;
        end
        if (nb_q != 2'h3) begin
          nb_q <= nb_q + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // commit at stop; data bytes counted excluding the command byte
  logic [1:0] dlen;
  logic       fin_wr;
  logic       no_pec;
  logic       pec_ok;
  logic       good_wr;
  logic       imb_hi;
  assign dlen    = (nb_q == 2'h0) ? 2'h0 : nb_q - 2'h1;
  assign fin_wr  = stop_ev && !rd_q && (nb_q != 2'h0);
  assign no_pec  = (dlen == len_of(cmd_q));
  assign pec_ok  = (dlen == len_of(cmd_q) + 2'h1) && (crc_q == 8'h00);
  assign good_wr = fin_wr && (len_of(cmd_q) != 2'h3) && (no_pec || pec_ok);
  assign imb_hi  = (I_PHASE_IMBAL > `PMT_IMBAL_MANT);

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      nvm_q <= {PHASE_EN_DEF, `PMT_RST_UVOFS, `PMT_RST_OVOFS, MAX_PHASE_DEF,
                `PMT_RST_UVLO, `PMT_RST_SHED, `PMT_RST_RAMP, `PMT_RST_SLEW,
                `PMT_RST_FREQ, `PMT_RST_BOOTV, `PMT_RST_MAXCUR};
      O_NVM_STORE <= 1'b0;
    end else begin
      O_NVM_STORE <= good_wr && (cmd_q == `PMT_CMD_STORE);
      if (good_wr && cmd_q == `PMT_CMD_STORE) begin
        nvm_q <= cfg_q;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg_q <= '0;
    end else if (boot_ld) begin
      cfg_q <= nvm_q;
      if (stp_s2[23]) begin
        cfg_q[`PMT_IDX_MAXCUR] <= stp_s2[15:8];
        cfg_q[`PMT_IDX_BOOTV]  <= stp_s2[7:0];
      end
    end else if (good_wr && idx_of(cmd_q) != `PMT_IDX_NONE) begin
      cfg_q[idx_of(cmd_q)] <= d0_q;
    end
  end

  assign O_CFG = cfg_q;

  // faults and alert: a new event wins over a clear in the same cycle
  logic imb_q;
  logic cml_set;
  logic clr_ev;
  logic ara_done;
  assign cml_set  = fin_wr && !good_wr;
  assign clr_ev   = good_wr && (cmd_q == `PMT_CMD_CLEAR);
  assign ara_done = ara_q && rd_q && (st_q == ST_RACK) && bit_ev;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      imb_q   <= 1'b0;
      cml_q   <= 1'b0;
      mfr_q   <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      imb_q <= imb_hi;
      if (cml_set) begin
        cml_q <= 1'b1;
      end else if (clr_ev) begin
        cml_q <= 1'b0;
      end
      if (imb_hi && !imb_q) begin
        mfr_q <= 1'b1;
      end else if (clr_ev) begin
        mfr_q <= 1'b0;
      end
      if ((imb_hi && !imb_q) || cml_set) begin
        alert_q <= 1'b1;
      end else if (clr_ev || ara_done) begin
        alert_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_STATUS <= 16'h0000;
    end else begin
      O_STATUS <= 16'(({15'h0000, cml_q} << `PMT_ST_CML_BIT) |
                      ({15'h0000, mfr_q} << `PMT_ST_MFR_BIT));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_write_done;
    good_wr && idx_of(cmd_q) != `PMT_IDX_NONE && !boot_ld;
  endsequence

  property p_sda_on_fall;
    $rose(O_PINS.sda_oe) |-> $past(scl_fall) || $past(scl_fall, 2);
  endproperty
  a_sda_on_fall: assert property (p_sda_on_fall) else $error("sda driven off a low phase");

  property p_ara_only_alerting;
    (st_q == ST_ACK && ack_en_q && !pos_q && ara_q) |-> alert_q;
  endproperty
  a_ara_only_alerting: assert property (p_ara_only_alerting) else $error("ara ack without alert");

  property p_nvm_only_store;
    $changed(nvm_q) |-> O_NVM_STORE && $past(cmd_q) == `PMT_CMD_STORE;
  endproperty
  a_nvm_only_store: assert property (p_nvm_only_store) else $error("stored copy changed");

  property p_cfg_write;
    s_write_done |=> cfg_q[idx_of($past(cmd_q))] == $past(d0_q);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("setting not written");

  sequence s_fault_shown;
    cml_q ##1 O_STATUS[`PMT_ST_CML_BIT];
  endsequence

  property p_bad_cmd_faults;
    (fin_wr && len_of(cmd_q) == 2'h3) |=> s_fault_shown;
  endproperty
  a_bad_cmd_faults: assert property (p_bad_cmd_faults) else $error("bad code not flagged");

  property p_bad_cmd_keeps;
    (fin_wr && len_of(cmd_q) == 2'h3 && !boot_ld) |=> $stable(cfg_q);
  endproperty
  a_bad_cmd_keeps: assert property (p_bad_cmd_keeps) else $error("bad code altered setting");

  sequence s_alert_shown;
    alert_q ##1 O_PINS.alert_oe;
  endsequence

  property p_imbal_alert;
    (imb_hi && !imb_q) |=> s_alert_shown;
  endproperty
  a_imbal_alert: assert property (p_imbal_alert) else $error("imbalance not alerted");

  property p_pec_bad;
    (fin_wr && dlen == len_of(cmd_q) + 2'h1 && crc_q != 8'h00 && !boot_ld) |=>
      $stable(cfg_q) && cml_q;
  endproperty
  a_pec_bad: assert property (p_pec_bad) else $error("bad checksum accepted");

  property p_no_pec;
    (fin_wr && no_pec && len_of(cmd_q) == 2'h1 && !boot_ld) |=>
      cfg_q[idx_of($past(cmd_q))] == $past(d0_q) && $stable(cml_q);
  endproperty
  a_no_pec: assert property (p_no_pec) else $error("write without checksum refused");

  property p_vid_word;
    (tx_load && !ara_q && cmd_q == `PMT_CMD_BOOTVID && txi_q == 3'h0) |->
      nxt_tx == cfg_q[`PMT_IDX_BOOTV];
  endproperty
  a_vid_word: assert property (p_vid_word) else $error("boot vid word wrong");

endmodule

`default_nettype wire

// ### shared/pmt_target_params.svh
// constants for the power-management serial target: command codes, defaults, bit positions
// assumes inclusion by the package and the target module only
// Operation
// - works at both standard and fast bus clock rates.
// - never holds the serial clock low; the host paces every bit.
// - when the host clocks a checksum byte, produce or check it; the alert response sends FF in its place.
// - stop without a checksum byte completes the transfer without checking.
// - numeric data keeps a fixed exponent; exponent changes are not honored.
// - no coefficient-based direct data format anywhere.
// - answer the alert response address only when alerting, returning own address.
// - settings stay volatile until store-all-defaults commits them as power-up defaults; the stored copy itself returns to fixed defaults at reset.
// - linear words hold 11-bit signed mantissa and 5-bit signed exponent.
// - telemetry reads back in linear format; voltage words in VID format.
// - imbalance limit is linear, default three; exceeding it raises the alert.
// - code DA reads and writes the max current byte, strap or stored default.
// - code DB reads and writes the boot voltage byte, strap or stored default.
// - code DC holds frequency and rise time selection byte.
// - code DD holds slew and mode byte; code DE holds ramp amplitude.
// - code DF holds phase shedding threshold byte.
// - code E0 holds input undervoltage lockout threshold, default one.
// - code E4 sets max active phases; code E8 enables individual phases.
// - codes E5 and E6 hold overvoltage and undervoltage offsets.
// - code E7 returns boot voltage as a read-only VID word.
// - code FC answers a word read with the fixed identification code.
// - code 79 returns the two-byte summary status word.
`ifndef PMT_TARGET_PARAMS_SVH
`define PMT_TARGET_PARAMS_SVH

`define PMT_ARA_ADDR      7'h0c
`define PMT_CMD_CLEAR     8'h03
`define PMT_CMD_STORE     8'h11
`define PMT_CMD_STATUS    8'h79
`define PMT_CMD_MAXCUR    8'hda
`define PMT_CMD_BOOTV     8'hdb
`define PMT_CMD_FREQ      8'hdc
`define PMT_CMD_SLEW      8'hdd
`define PMT_CMD_RAMP      8'hde
`define PMT_CMD_SHED      8'hdf
`define PMT_CMD_UVLO      8'he0
`define PMT_CMD_IMBAL     8'he3
`define PMT_CMD_MAXPH     8'he4
`define PMT_CMD_OVOFS     8'he5
`define PMT_CMD_UVOFS     8'he6
`define PMT_CMD_BOOTVID   8'he7
`define PMT_CMD_PHEN      8'he8
`define PMT_CMD_DEVID     8'hfc

`define PMT_RST_MAXCUR    8'hb4
`define PMT_RST_BOOTV     8'h97
`define PMT_RST_FREQ      8'h20
`define PMT_RST_SLEW      8'h89
`define PMT_RST_RAMP      8'h06
`define PMT_RST_SHED      8'h09
`define PMT_RST_UVLO      8'h01
`define PMT_RST_OVOFS     8'h0f
`define PMT_RST_UVOFS     8'h03
`define PMT_IMBAL_MANT    11'h003
`define PMT_IMBAL_EXP     5'h00

`define PMT_IDX_MAXCUR    4'h0
`define PMT_IDX_BOOTV     4'h1
`define PMT_IDX_NONE      4'hf
`define PMT_ST_CML_BIT    1
`define PMT_ST_MFR_BIT    12
`define PMT_CRC_POLY      8'h07
`define PMT_BOOT_WAIT     2'h3

`endif

// ### shared/pmt_pkg.sv
// types shared by the power-management serial target
// assumes the constants header sits beside it
`default_nettype none

package pmt_pkg;
  `include "pmt_target_params.svh"

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_RACK
  } pmt_state_e;

  // open-drain pins: output level is always low, the enable decides
  typedef struct packed {
    logic sda_o;
    logic sda_oe;
    logic alert_o;
    logic alert_oe;
  } pmt_pins_s;

  // eleven writable bytes, index order DA DB DC DD DE DF E0 E4 E5 E6 E8
  typedef logic [10:0][7:0] pmt_cfg_t;
endpackage

`default_nettype wire

// ### test/pmt_host_model.sv
// host controller model: paces the bus clock and pulls the data wire low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none

module pmt_host_model (
  // pacing tick
  input  wire logic i_tick,
  // bus wires
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // ticks per clock phase: 22/10 is fast mode, 74/64 standard mode
  int lo = 22;
  int hi = 10;

  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // data moves well after the clock fall so no false start or stop is seen
  task automatic bit_io(input logic b, output logic r);
    repeat (4) @(posedge i_tick);
    o_sda_low <= !b;
    repeat (lo - 4) @(posedge i_tick);
    o_scl <= 1'b1;
    repeat (hi) @(posedge i_tick);
    r = i_sda;
    o_scl <= 1'b0;
  endtask

  task automatic start();
    repeat (4) @(posedge i_tick);
    o_sda_low <= 1'b0;
    repeat (lo) @(posedge i_tick);
    o_scl <= 1'b1;
    repeat (hi) @(posedge i_tick);
    o_sda_low <= 1'b1;
    repeat (hi) @(posedge i_tick);
    o_scl <= 1'b0;
  endtask

  // clock stands high after this until the next frame
  task automatic stop();
    repeat (4) @(posedge i_tick);
    o_sda_low <= 1'b1;
    repeat (lo) @(posedge i_tick);
    o_scl <= 1'b1;
    repeat (hi) @(posedge i_tick);
    o_sda_low <= 1'b0;
    repeat (lo) @(posedge i_tick);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ak = !r;
  endtask

  task automatic rbyte(input logic ack_it, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack_it, r);
  endtask
endmodule

`default_nettype wire

// ### test/pmbus_target_command_interface_tb.sv
// self-checking bench for the power-management serial target
// assumes pmt_pkg, pmt_target and pmt_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module pmbus_target_command_interface_tb;
  import pmt_pkg::*;
  localparam logic [6:0]  ADDR = 7'h4a;
  localparam logic [15:0] ID = 16'h5a3c; // arbitrary value
  localparam int LIMIT = 100000;
  localparam logic [7:0] CODES [11] = '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf,
                                        8'he0, 8'he4, 8'he5, 8'he6, 8'he8};
  localparam logic [7:0] DEFS [11] = '{8'hb4, 8'h97, 8'h20, 8'h89, 8'h06, 8'h09,
                                       8'h01, 8'h06, 8'h0f, 8'h03, 8'h3f};
  logic        clk = 1'b0;
  logic        tick = 1'b0;
  logic        rst_n = 1'b0;
  logic        mode = 1'b0;
  logic [7:0]  s_max_operating_current = 8'h00;
  logic [7:0]  s_boot_voltage = 8'h00;
  logic [10:0] imbal = 11'h000;
  logic        scl;
  logic        h_low;
  logic        nvm;
  wire logic   sda;
  pmt_pins_s   pins;
  pmt_cfg_t    cfg;
  logic [15:0] status;
  logic [31:0] seed = 32'hbf2de5da;
  logic [7:0]  exp_q [11];
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          stores = 0;

  always #12.5 clk = ~clk;
  // link tick: 64 ns period, phase unrelated to the system clock
  initial begin
    #7;
    forever #32 tick = ~tick;
  end
  assign sda = !(h_low | pins.sda_oe);

  pmt_target #(.DEVICE_ID(ID)) dut_u (
    .I_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda), .O_PINS(pins),
    .I_ADDR_STRAP(ADDR), .I_STRAP_MODE(mode), .I_STRAP_MAX_OPERATING_CURRENT(s_max_operating_current),
    .I_STRAP_BOOT_VOLTAGE(s_boot_voltage), .I_PHASE_IMBAL(imbal), .O_CFG(cfg),
    .O_STATUS(status), .O_NVM_STORE(nvm));
  pmt_host_model h_u (.i_tick(tick), .i_sda(sda), .o_scl(scl), .o_sda_low(h_low));

  always @(posedge clk) begin
    cyc++;
    if (nvm === 1'b1) stores++;
    if (cyc == LIMIT) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    return c;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      error_cnt++;
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic do_reset(input logic m);
    @(posedge clk);
    rst_n <= 1'b0;
    mode <= m;
    s_max_operating_current <= rnd();
    s_boot_voltage <= rnd();
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    settle();
  endtask

  task automatic cfg_chk();
    for (int i = 0; i < 11; i++) chk("cfg byte", exp_q[i], cfg[i]);
  endtask

  // pec: 0 none, 1 good checksum, 2 corrupted checksum
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input int n, input int pec);
    logic [7:0] crc;
    logic ak;
    h_u.start();
    h_u.wbyte({ADDR, 1'b0}, ak);
    chk("write ack", 1'b1, ak);
    h_u.wbyte(c, ak);
    crc = crc8(crc8(8'h00, {ADDR, 1'b0}), c);
    if (n > 0) h_u.wbyte(d, ak);
    if (n > 0) crc = crc8(crc, d);
    if (pec > 0) h_u.wbyte(crc ^ ((pec == 2) ? 8'h01 : 8'h00), ak);
    h_u.stop();
    settle();
  endtask

  task automatic rd(input logic [7:0] c, input int n, output logic [15:0] v);
    logic [7:0] crc, b;
    logic ak;
    v = 16'h0000;
    h_u.start();
    h_u.wbyte({ADDR, 1'b0}, ak);
    h_u.wbyte(c, ak);
    h_u.start();
    h_u.wbyte({ADDR, 1'b1}, ak);
    chk("read ack", 1'b1, ak);
    crc = crc8(crc8(crc8(8'h00, {ADDR, 1'b0}), c), {ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      h_u.rbyte(1'b1, b);
      v[8*i +: 8] = b;
      crc = crc8(crc, b);
    end
    h_u.rbyte(1'b0, b);
    chk("read checksum", crc, b);
    h_u.stop();
    settle();
  endtask

  task automatic ara(output logic ak, output logic [7:0] b);
    b = 8'h00;
    h_u.start();
    h_u.wbyte({7'h0c, 1'b1}, ak);
    if (ak) h_u.rbyte(1'b0, b);
    h_u.stop();
    settle();
  endtask

  initial begin
    logic [15:0] v;
    logic [7:0] b, d;
    logic ak;
    do_reset(1'b1);
    exp_q = DEFS;
    exp_q[0] = s_max_operating_current;
    exp_q[1] = s_boot_voltage;
    cfg_chk();
    do_reset(1'b0);
    exp_q = DEFS;
    cfg_chk();
    $display("test reset_defaults done");
    for (int i = 0; i < 11; i++) begin
      d = rnd();
      wr(CODES[i], d, 1, 1);
      exp_q[i] = d;
    end
    cfg_chk();
    rd(CODES[1], 1, v);
    chk("boot byte", {8'h00, exp_q[1]}, v);
    rd(CODES[10], 1, v);
    chk("phase mask", {8'h00, exp_q[10]}, v);
    chk("no store yet", 16'h0000, 16'(stores));
    $display("test rw_all done");
    d = rnd();
    wr(8'hda, d, 1, 0);
    exp_q[0] = d;
    wr(8'hdb, ~exp_q[1], 1, 2);
    wr(8'h42, 8'h5a, 1, 0);
    wr(8'he3, 8'h10, 1, 0);
    cfg_chk();
    chk("fault flag", 16'h0001, {15'h0, status[1]});
    chk("fault alert", 16'h0001, {15'h0, pins.alert_oe});
    rd(8'h79, 2, v);
    chk("status word", 16'h0002, v & 16'h0002);
    rd(8'he3, 2, v);
    chk("imbalance limit", 16'h0003, v);
    rd(8'hfc, 2, v);
    chk("identifier", ID, v);
    rd(8'he7, 2, v);
    chk("boot vid", {8'h00, exp_q[1]}, v);
    h_u.lo = 74;
    h_u.hi = 64;
    wr(8'h03, 8'h00, 0, 0);
    h_u.lo = 22;
    h_u.hi = 10;
    chk("fault cleared", 16'h0000, {15'h0, status[1]});
    $display("test faults done");
    ara(ak, b);
    chk("ara idle", 16'h0000, {15'h0, ak});
    h_u.start();
    h_u.wbyte({ADDR ^ 7'h01, 1'b0}, ak);
    h_u.stop();
    chk("foreign nack", 16'h0000, {15'h0, ak});
    @(posedge clk);
    imbal <= 11'h003;
    settle();
    chk("no alert at limit", 16'h0000, {15'h0, pins.alert_oe});
    @(posedge clk);
    imbal <= 11'h004;
    settle();
    chk("imbalance alert", 16'h0001, {15'h0, pins.alert_oe});
    chk("imbalance flag", 16'h0001, {15'h0, status[12]});
    ara(ak, b);
    chk("ara ack", 16'h0001, {15'h0, ak});
    chk("ara address", {9'h0, ADDR}, {9'h0, b[7:1]});
    chk("alert released", 16'h0000, {15'h0, pins.alert_oe});
    $display("test alert done");
    wr(8'h11, 8'h00, 0, 1);
    chk("store pulse", 16'h0001, 16'(stores));
    cfg_chk();
    $display("test store done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
